// [gps_regs.sv]
`timescale 1ns/100ps
module gps_regs
    import gps_pkg::*;
#(
    parameter logic [7:0] REVISION_CODE = 8'h5a  // Arbitrary value
)
(
    input  wire logic                  sys_clk,
    input  wire logic                  resetn,
    input  wire logic [ADDR_W-1:0]     addr,
    input  wire logic [DATA_W-1:0]     wdata,
    input  wire logic                  wr_stb,
    input  wire logic                  rd_stb,
    output logic [DATA_W-1:0]          rdata,
    output logic                       soft_device_reset,
    output logic                       core_a_half1_sel,
    output logic                       core_a_half2_sel,
    output logic                       core_b_half1_sel,
    output logic                       core_b_half2_sel,
    output logic                       core_c_half1_sel,
    output logic                       core_c_half2_sel,
    output logic                       core_d_half1_sel,
    output logic                       core_d_half2_sel,
    output logic                       top_digital_page_sel,
    output logic                       channel_a_page_sel,
    output logic                       channel_b_page_sel,
    output logic                       channel_c_page_sel,
    output logic                       channel_d_page_sel,
    output logic                       link_pair_ab_sel,
    output logic                       link_pair_cd_sel,
    output logic [PAGE_CNT-1:0]        page_wr,
    output logic [PAGE_CNT-1:0]        page_rd,
    output logic [ADDR_W-1:0]          page_addr,
    output logic [DATA_W-1:0]          page_wdata
);
    typedef struct packed {
        logic [7:0]           gen_ctrl;
        logic [7:0]           core_sel;
        logic [7:0]           block_sel;
        logic [2:0]           rst_cnt;
        logic                 rst_busy;
        logic [7:0]           rdata;
        logic [PAGE_CNT-1:0]  page_wr;
        logic [PAGE_CNT-1:0]  page_rd;
        logic [7:0]           page_addr;
        logic [7:0]           page_wdata;
    } gps_state_t;

    gps_state_t state_reg;
    gps_state_t state_next;
    logic [PAGE_CNT-1:0] hit_wr;
    logic [PAGE_CNT-1:0] hit_rd;

    function automatic logic is_page(input logic [7:0] a);
        is_page = (a >= PAGE_BASE);
    endfunction

    gps_page_route u_route_wr (
        .core_sel  (state_reg.core_sel),
        .block_sel (state_reg.block_sel),
        .page_acc  (wr_stb && is_page(addr)),
        .page_hit  (hit_wr)
    );
    gps_page_route u_route_rd (
        .core_sel  (state_reg.core_sel),
        .block_sel (state_reg.block_sel),
        .page_acc  (rd_stb && is_page(addr)),
        .page_hit  (hit_rd)
    );

    always_comb
    begin
        state_next = state_reg;
        state_next.rdata = 8'h00;
        state_next.page_wr = hit_wr;
        state_next.page_rd = hit_rd;
        if (wr_stb || rd_stb)
        begin
            state_next.page_addr = addr;
        end
        if (wr_stb)
        begin
            state_next.page_wdata = wdata;
        end
        // Soft reset pulse held for a few cycles, then self-clears
        if (state_reg.rst_busy)
        begin
            if (state_reg.rst_cnt == SOFT_RST_LAST)
            begin
                state_next.rst_busy = 1'b0;
                state_next.rst_cnt = 3'h0;
                state_next.gen_ctrl[GEN_SOFT_RST] = 1'b0;
            end
            else
            begin
                state_next.rst_cnt = state_reg.rst_cnt + 3'h1;
            end
        end
        if (wr_stb)
        begin
            case (addr)
                OFF_GEN_CTRL:
                begin
                    state_next.gen_ctrl = wdata;
                    if (wdata[GEN_SOFT_RST])
                    begin
                        state_next.rst_busy = 1'b1;
                        state_next.rst_cnt = 3'h0;
                    end
                end
                OFF_CORE_SEL:  state_next.core_sel = wdata;
                OFF_BLOCK_SEL: state_next.block_sel = wdata & BLOCK_SEL_MASK;
                default: ; // Revision writes ignored
            endcase
        end
        if (rd_stb)
        begin
            case (addr)
                OFF_GEN_CTRL:  state_next.rdata = state_reg.gen_ctrl;
                OFF_REVISION:  state_next.rdata = REVISION_CODE;
                OFF_CORE_SEL:  state_next.rdata = state_reg.core_sel;
                OFF_BLOCK_SEL: state_next.rdata = state_reg.block_sel;
                default:       state_next.rdata = 8'h00;
            endcase
        end
        // Soft reset clears selects, overriding a same-cycle select write
        if (state_reg.rst_busy)
        begin
            state_next.core_sel = RST_CORE_SEL;
            state_next.block_sel = RST_BLOCK_SEL;
            state_next.page_wr = '0;
            state_next.page_rd = '0;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign rdata = state_reg.rdata;
    assign soft_device_reset = state_reg.rst_busy;
    assign {core_d_half2_sel, core_d_half1_sel, core_c_half2_sel, core_c_half1_sel,
            core_b_half2_sel, core_b_half1_sel, core_a_half2_sel,
            core_a_half1_sel} = state_reg.core_sel;
    assign {link_pair_cd_sel, link_pair_ab_sel, channel_d_page_sel, channel_c_page_sel,
            channel_b_page_sel, channel_a_page_sel,
            top_digital_page_sel} = state_reg.block_sel[6:0];
    assign page_wr = state_reg.page_wr;
    assign page_rd = state_reg.page_rd;
    assign page_addr = state_reg.page_addr;
    assign page_wdata = state_reg.page_wdata;

    sequence s_rst_write;
        wr_stb && addr == OFF_GEN_CTRL && wdata[GEN_SOFT_RST];
    endsequence

    AST_REV_READ: assert property (@(posedge sys_clk) disable iff (!resetn)
        rd_stb && addr == OFF_REVISION |=> rdata == REVISION_CODE)
        else $error("revision read wrong");
    AST_SOFT_RST: assert property (@(posedge sys_clk) disable iff (!resetn)
        s_rst_write |=> soft_device_reset [*4] ##1 !soft_device_reset)
        else $error("soft reset pulse wrong");
    AST_RST_CLEARS: assert property (@(posedge sys_clk) disable iff (!resetn)
        soft_device_reset |=> state_reg.core_sel == 8'h00 && state_reg.block_sel == 8'h00)
        else $error("soft reset did not clear selects");
    AST_CORE_WR: assert property (@(posedge sys_clk) disable iff (!resetn)
        wr_stb && addr == OFF_CORE_SEL && !soft_device_reset |=> core_d_half2_sel == $past(wdata[7])
        && core_a_half1_sel == $past(wdata[0]))
        else $error("core select write wrong");
    AST_BLK_B7: assert property (@(posedge sys_clk) disable iff (!resetn)
        rd_stb && addr == OFF_BLOCK_SEL |=> rdata[7] == 1'b0)
        else $error("block bit 7 not zero");
    AST_BLK_WR: assert property (@(posedge sys_clk) disable iff (!resetn)
        wr_stb && addr == OFF_BLOCK_SEL && !soft_device_reset
        |=> top_digital_page_sel == $past(wdata[0]) && link_pair_cd_sel == $past(wdata[6]))
        else $error("block select write wrong");
    AST_ROUTE_NONE: assert property (@(posedge sys_clk) disable iff (!resetn)
        wr_stb && is_page(addr) && state_reg.core_sel == 8'h00 && state_reg.block_sel == 8'h00
        && !soft_device_reset |=> page_wr == '0)
        else $error("write routed with nothing selected");
    AST_ROUTE_A1: assert property (@(posedge sys_clk) disable iff (!resetn)
        rd_stb && is_page(addr) && !soft_device_reset |=> page_rd[0] == $past(core_a_half1_sel))
        else $error("read routing wrong");
    AST_RESET_ZERO: assert property (@(posedge sys_clk)
        $rose(resetn) |-> state_reg.core_sel == 8'h00 && state_reg.block_sel == 8'h00
        && state_reg.gen_ctrl == 8'h00)
        else $error("reset values not zero");

    sequence s_page_write;
        wr_stb && is_page(addr) && !soft_device_reset;
    endsequence

    AST_ROUTE_HIT: assert property (@(posedge sys_clk) disable iff (!resetn)
        s_page_write |=> page_wr[14:8] == $past(state_reg.block_sel[6:0])
        && page_wr[7:0] == $past(state_reg.core_sel))
        else $error("page write routed to wrong pages");
    AST_ROUTE_IDLE: assert property (@(posedge sys_clk) disable iff (!resetn)
        !(wr_stb && is_page(addr)) |=> page_wr == '0)
        else $error("page write strobe without access");
    AST_SOFT_MUTE: assert property (@(posedge sys_clk) disable iff (!resetn)
        soft_device_reset |=> page_wr == '0 && page_rd == '0)
        else $error("page strobe during soft reset");
    AST_BLK_B7_CLR: assert property (@(posedge sys_clk) disable iff (!resetn)
        state_reg.block_sel[7] == 1'b0)
        else $error("block bit 7 stored");
    AST_REV_WR: assert property (@(posedge sys_clk) disable iff (!resetn)
        wr_stb && addr == OFF_REVISION && !soft_device_reset
        |=> $stable(state_reg.core_sel) && $stable(state_reg.block_sel))
        else $error("revision write changed state");
    AST_GEN_WR: assert property (@(posedge sys_clk) disable iff (!resetn)
        wr_stb && addr == OFF_GEN_CTRL |=> state_reg.gen_ctrl == $past(wdata))
        else $error("general control write lost");
endmodule

// [gps_pkg.sv]
package gps_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 8;
    localparam logic [7:0]  OFF_GEN_CTRL    = 8'h00;
    localparam logic [7:0]  OFF_REVISION    = 8'h04;
    localparam logic [7:0]  OFF_CORE_SEL    = 8'h11;
    localparam logic [7:0]  OFF_BLOCK_SEL   = 8'h12;
    localparam logic [7:0]  PAGE_BASE       = 8'h20;
    localparam logic [7:0]  RST_GEN_CTRL    = 8'h00;
    localparam logic [7:0]  RST_CORE_SEL    = 8'h00;
    localparam logic [7:0]  RST_BLOCK_SEL   = 8'h00;
    localparam int          GEN_SOFT_RST    = 0;
    localparam int          GEN_WRITE_ONE   = 7;
    localparam logic [7:0]  BLOCK_SEL_MASK  = 8'h7f;
    localparam int          SOFT_RST_CYC    = 4;
    localparam logic [2:0]  SOFT_RST_LAST   = 3'h3;
    localparam int          PAGE_CNT        = 15;
endpackage

// [gps_page_route.sv]
`timescale 1ns/100ps
module gps_page_route
    import gps_pkg::*;
(
    input  wire logic [7:0]            core_sel,
    input  wire logic [7:0]            block_sel,
    input  wire logic                  page_acc,
    output logic [PAGE_CNT-1:0]        page_hit
);
    // Bits 7..0 core halves, then block bits 6..0 above them
    always_comb
    begin
        page_hit = {PAGE_CNT{page_acc}} & {block_sel[6:0], core_sel};
    end
endmodule

// [tb_top.sv]
`timescale 1ns/100ps
module tb_top
    import gps_pkg::*;
;
    localparam logic [7:0] REV = 8'h3c;  // Arbitrary value
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] r;} gps_row_t;
    logic                  sys_clk;
    logic                  resetn;
    logic [7:0]            addr;
    logic [7:0]            wdata;
    logic                  wr_stb;
    logic                  rd_stb;
    logic [7:0]            rdata;
    logic                  soft_device_reset;
    logic [7:0]            core_v;
    logic [6:0]            blk_v;
    logic [PAGE_CNT-1:0]   page_wr;
    logic [PAGE_CNT-1:0]   page_rd;
    logic [7:0]            page_addr;
    logic [7:0]            page_wdata;
    int                    err_count;
    int                    n_compared;
    gps_row_t              rows [5];

    gps_regs #(.REVISION_CODE(REV)) gps_regs_i (
        .sys_clk(sys_clk), .resetn(resetn), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .soft_device_reset(soft_device_reset),
        .core_a_half1_sel(core_v[0]), .core_a_half2_sel(core_v[1]),
        .core_b_half1_sel(core_v[2]), .core_b_half2_sel(core_v[3]),
        .core_c_half1_sel(core_v[4]), .core_c_half2_sel(core_v[5]),
        .core_d_half1_sel(core_v[6]), .core_d_half2_sel(core_v[7]),
        .top_digital_page_sel(blk_v[0]), .channel_a_page_sel(blk_v[1]),
        .channel_b_page_sel(blk_v[2]), .channel_c_page_sel(blk_v[3]),
        .channel_d_page_sel(blk_v[4]), .link_pair_ab_sel(blk_v[5]),
        .link_pair_cd_sel(blk_v[6]), .page_wr(page_wr), .page_rd(page_rd),
        .page_addr(page_addr), .page_wdata(page_wdata));

    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
        @(posedge sys_clk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        #1 check(nm, rdata, exp);
    endtask

    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        #200000;
        err_count++;
        finish_test();
    end

    initial
    begin
        resetn = 1'b0; addr = 8'h00; wdata = 8'h00; wr_stb = 1'b0; rd_stb = 1'b0;
        err_count = 0; n_compared = 0;
        rows[0] = '{OFF_CORE_SEL, 8'hb1, 8'hb1};
        rows[1] = '{OFF_REVISION, 8'h00, REV};
        rows[2] = '{OFF_GEN_CTRL, 8'h80, 8'h80};  // Host keeps bit 7 set
        rows[3] = '{8'h07, 8'h33, 8'h00};
        rows[4] = '{OFF_BLOCK_SEL, 8'hd3, 8'h53};
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        #1 check("core select", core_v, 16'h0000);
        check("block select", blk_v, 16'h0000);
        rd(OFF_GEN_CTRL, 8'h00, "general control");
        rd(OFF_CORE_SEL, 8'h00, "core select reg");
        rd(OFF_BLOCK_SEL, 8'h00, "block select reg");
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].r, "row readback");
        end
        check("core select", core_v, 16'h00b1);
        check("block select", blk_v, 16'h0053);
        wr(8'h30, 8'h3c);
        check("page write", page_wr, {1'b0, 7'h53, 8'hb1});
        check("page addr", page_addr, 16'h0030);
        check("page data", page_wdata, 16'h003c);
        rd(8'h31, 8'h00, "page read data");
        check("page read", page_rd, {1'b0, 7'h53, 8'hb1});
        wr(OFF_CORE_SEL, 8'h00);
        wr(OFF_BLOCK_SEL, 8'h00);
        wr(8'h40, 8'h11);
        check("idle page write", page_wr, 16'h0000);
        wr(OFF_CORE_SEL, 8'hff);
        wr(OFF_GEN_CTRL, 8'h81);  // Bit 7 set, bits 6..1 clear
        check("soft reset", soft_device_reset, 16'h0001);
        @(posedge sys_clk);
        #1 check("core after reset", core_v, 16'h0000);
        repeat (SOFT_RST_CYC - 2) @(posedge sys_clk);
        #1 check("soft reset end", soft_device_reset, 16'h0001);
        @(posedge sys_clk);
        #1 check("soft reset off", soft_device_reset, 16'h0000);
        rd(OFF_GEN_CTRL, 8'h80, "general control");
        rd(OFF_CORE_SEL, 8'h00, "core select reg");
        wr(OFF_CORE_SEL, 8'h3c);
        wr(OFF_BLOCK_SEL, 8'h0f);
        @(posedge sys_clk);
        resetn <= 1'b0;
        #1 check("core in reset", core_v, 16'h0000);
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        #1 check("block after reset", blk_v, 16'h0000);
        rd(OFF_BLOCK_SEL, 8'h00, "block select reg");
        rd(OFF_GEN_CTRL, 8'h00, "general control");
        finish_test();
    end
endmodule
